// [hdl/aami_pkg.sv]
// Constants for the antenna axis motion interlock
package aami_pkg;
	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_AZ_CW_LIM = 8'h04;
	localparam logic [7:0] ADDR_AZ_CCW_LIM = 8'h08;
	localparam logic [7:0] ADDR_PL_CW_LIM = 8'h0C;
	localparam logic [7:0] ADDR_PL_CCW_LIM = 8'h10;
	localparam logic [7:0] ADDR_CFG = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	localparam logic [7:0] ADDR_FAULT = 8'h1C;
	// ----------------------------------------
	// Command bits: one cw/ccw or up/down pair per axis, plus stow
	// ----------------------------------------
	localparam int CMD_AZ_CW = 0;
	localparam int CMD_AZ_CCW = 1;
	localparam int CMD_EL_UP = 2;
	localparam int CMD_EL_DN = 3;
	localparam int CMD_PL_CW = 4;
	localparam int CMD_PL_CCW = 5;
	localparam int CMD_STOW = 6;
	localparam int CMD_W = 7;
	// Status bits
	localparam int ST_AZ_STOW = 0;
	localparam int ST_EL_DOWN = 1;
	localparam int ST_EL_STOW = 2;
	localparam int ST_EL_UP = 3;
	localparam int ST_PL_STOW = 4;
	localparam int ST_AZ_CW = 5;
	localparam int ST_AZ_CCW = 6;
	localparam int ST_PL_CW = 7;
	localparam int ST_PL_CCW = 8;
	localparam int ST_RELAY = 9;
	localparam int ST_STOW_TO = 10;
	localparam int ST_W = 11;
	localparam int CFG_PL_STOW_EN = 0;
	localparam logic [11:0] LIM_RESET = 12'h000;
	localparam int POS_W = 12;
	localparam int NAX = 3;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam longint CLK_HZ = 40000000;
	localparam longint RELAY_HOLD_S = 5;
	localparam longint JAM_TIMEOUT_S = 3;
	localparam longint STOW_TIMEOUT_MIN = 5;
	localparam longint DEBOUNCE_US = 1000;
	localparam int RELAY_HOLD_CYC = int'(RELAY_HOLD_S * CLK_HZ);
	localparam int JAM_CYC = int'(JAM_TIMEOUT_S * CLK_HZ);
	// Five minutes of cycles overflows 32 bits, so kept wide
	localparam longint STOW_CYC = STOW_TIMEOUT_MIN * 60 * CLK_HZ;
	localparam int DEBOUNCE_CYC = int'(DEBOUNCE_US * CLK_HZ / 1000000);
	localparam int CNT_W = 34;
endpackage : aami_pkg

// [hdl/aami_interlock.sv]
// Three-axis motion interlock with APB register access
`timescale 1ns/100ps
module aami_interlock #(
	parameter int RELAY_CYC = aami_pkg::RELAY_HOLD_CYC,
	parameter int JAM_TO_CYC = aami_pkg::JAM_CYC,
	parameter longint STOW_TO_CYC = aami_pkg::STOW_CYC,
	parameter int DEB_CYC = aami_pkg::DEBOUNCE_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sw_az_stow_n,
	input wire logic sw_el_down_n,
	input wire logic sw_el_stow_n,
	input wire logic sw_el_up_n,
	input wire logic sw_pl_stow_n,
	input wire logic [11:0] az_pos,
	input wire logic [11:0] el_pos,
	input wire logic [11:0] pl_pos,
	output logic drv_az_cw,
	output logic drv_az_ccw,
	output logic drv_el_up,
	output logic drv_el_dn,
	output logic drv_pl_cw,
	output logic drv_pl_ccw,
	output logic safety_relay
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [aami_pkg::CMD_W-1:0] cmd_ff;
	logic [11:0] az_cw_lim_ff, az_ccw_lim_ff, pl_cw_lim_ff, pl_ccw_lim_ff;
	logic pl_stow_en_ff;
	logic [aami_pkg::NAX-1:0] jam_ff;
	logic [4:0] sw_raw;
	logic [4:0] sw_s1_ff, sw_s2_ff, sw_deb_ff;
	logic [4:0][15:0] deb_cnt_ff;
	logic az_stow, el_down, el_stow, el_up, pl_stow;
	logic az_cw_lim, az_ccw_lim, pl_cw_lim, pl_ccw_lim;
	logic [5:0] nxt_drv;
	logic [5:0] drv_ff;
	logic moving;
	logic [aami_pkg::CNT_W-1:0] relay_cnt_ff, stow_cnt_ff;
	logic relay_ff, stow_to_ff;
	logic [aami_pkg::NAX-1:0][aami_pkg::CNT_W-1:0] jam_cnt_ff;
	logic [aami_pkg::NAX-1:0][11:0] last_pos_ff;
	logic [aami_pkg::NAX-1:0][11:0] pos;
	logic [aami_pkg::NAX-1:0] ax_cmd;
	logic apb_wr, apb_rd;
	logic [aami_pkg::ST_W-1:0] status;

	assign pos = {pl_pos, el_pos, az_pos};
	// Elevation and pol contacts open at their limit; azimuth stow closes at it
	assign sw_raw = {sw_pl_stow_n, sw_el_up_n, sw_el_stow_n, sw_el_down_n,
		~sw_az_stow_n};

	// ----------------------------------------
	// Switch synchronise and debounce
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_sw
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sw_s1_ff[gi] <= 1'b0;
					sw_s2_ff[gi] <= 1'b0;
					sw_deb_ff[gi] <= 1'b0;
					deb_cnt_ff[gi] <= 16'h0000;
				end else begin
					sw_s1_ff[gi] <= sw_raw[gi];
					sw_s2_ff[gi] <= sw_s1_ff[gi];
					if (sw_s2_ff[gi] == sw_deb_ff[gi]) begin
						deb_cnt_ff[gi] <= 16'h0000;
					end else if (deb_cnt_ff[gi] >= 16'(DEB_CYC - 1)) begin
						sw_deb_ff[gi] <= sw_s2_ff[gi];
						deb_cnt_ff[gi] <= 16'h0000;
					end else begin
						deb_cnt_ff[gi] <= deb_cnt_ff[gi] + 16'h0001;
					end
				end
			end
		end
	endgenerate

	// Active-high limit conditions
	assign az_stow = sw_deb_ff[0];
	assign el_stow = sw_deb_ff[2];
	assign el_down = sw_deb_ff[1] | el_stow;
	assign el_up = sw_deb_ff[3];
	assign pl_stow = sw_deb_ff[4];
	// Higher position voltage means further clockwise
	assign az_cw_lim = az_pos >= az_cw_lim_ff;
	assign az_ccw_lim = az_pos <= az_ccw_lim_ff;
	assign pl_cw_lim = pl_pos >= pl_cw_lim_ff;
	assign pl_ccw_lim = pl_pos <= pl_ccw_lim_ff;

	// ----------------------------------------
	// Interlock gating
	// ----------------------------------------
	always_comb begin
		nxt_drv = 6'h00;
		if (!jam_ff[0]) begin
			nxt_drv[0] = cmd_ff[aami_pkg::CMD_AZ_CW] & ~az_cw_lim & ~el_down;
			nxt_drv[1] = cmd_ff[aami_pkg::CMD_AZ_CCW] & ~az_ccw_lim & ~el_down;
		end
		if (!jam_ff[1]) begin
			nxt_drv[2] = cmd_ff[aami_pkg::CMD_EL_UP] & ~el_up;
			// Below down position needs azimuth stow and, if fitted, pol stow
			nxt_drv[3] = cmd_ff[aami_pkg::CMD_EL_DN] & ~el_stow & ~stow_to_ff
				& (~el_down | (az_stow & (~pl_stow_en_ff | pl_stow)));
		end
		if (!jam_ff[2]) begin
			nxt_drv[4] = cmd_ff[aami_pkg::CMD_PL_CW] & ~pl_cw_lim;
			nxt_drv[5] = cmd_ff[aami_pkg::CMD_PL_CCW] & ~pl_ccw_lim;
		end
		// Opposite directions at once would short the drive
		if (nxt_drv[0] && nxt_drv[1]) begin
			nxt_drv[1:0] = 2'b00;
		end
		if (nxt_drv[2] && nxt_drv[3]) begin
			nxt_drv[3:2] = 2'b00;
		end
		if (nxt_drv[4] && nxt_drv[5]) begin
			nxt_drv[5:4] = 2'b00;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drv_ff <= 6'h00;
		end else begin
			drv_ff <= nxt_drv;
		end
	end
	assign {drv_pl_ccw, drv_pl_cw, drv_el_dn, drv_el_up, drv_az_ccw, drv_az_cw} = drv_ff;
	assign moving = |drv_ff;
	assign ax_cmd = {|drv_ff[5:4], |drv_ff[3:2], |drv_ff[1:0]};

	// ----------------------------------------
	// Safety relay hold-off
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			relay_ff <= 1'b0;
			relay_cnt_ff <= '0;
		end else if (moving) begin
			relay_ff <= 1'b1;
			relay_cnt_ff <= '0;
		end else if (relay_ff) begin
			if (relay_cnt_ff >= aami_pkg::CNT_W'(RELAY_CYC - 1)) begin
				relay_ff <= 1'b0;
			end else begin
				relay_cnt_ff <= relay_cnt_ff + 1'b1;
			end
		end
	end
	assign safety_relay = relay_ff;

	// ----------------------------------------
	// Jam detection, per axis
	// ----------------------------------------
	generate
		for (gi = 0; gi < aami_pkg::NAX; gi++) begin : g_jam
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					jam_ff[gi] <= 1'b0;
					jam_cnt_ff[gi] <= '0;
					last_pos_ff[gi] <= 12'h000;
				end else begin
					last_pos_ff[gi] <= pos[gi];
					if (!ax_cmd[gi] || pos[gi] != last_pos_ff[gi]) begin
						jam_cnt_ff[gi] <= '0;
					end else if (jam_cnt_ff[gi] >= aami_pkg::CNT_W'(JAM_TO_CYC - 1)) begin
						jam_cnt_ff[gi] <= '0;
					end else begin
						jam_cnt_ff[gi] <= jam_cnt_ff[gi] + 1'b1;
					end
					// Set wins over a same-cycle clear
					if (ax_cmd[gi] && pos[gi] == last_pos_ff[gi]
						&& jam_cnt_ff[gi] >= aami_pkg::CNT_W'(JAM_TO_CYC - 1)) begin
						jam_ff[gi] <= 1'b1;
					end else if (apb_wr && paddr == aami_pkg::ADDR_FAULT && pwdata[gi]) begin
						jam_ff[gi] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Stow elevation timeout
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stow_cnt_ff <= '0;
			stow_to_ff <= 1'b0;
		end else if (!cmd_ff[aami_pkg::CMD_STOW]) begin
			stow_cnt_ff <= '0;
			stow_to_ff <= 1'b0;
		end else if (drv_ff[3]) begin
			if (stow_cnt_ff >= aami_pkg::CNT_W'(STOW_TO_CYC - 1)) begin
				stow_to_ff <= 1'b1;
			end else begin
				stow_cnt_ff <= stow_cnt_ff + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// APB slave, zero wait states
	// ----------------------------------------
	assign apb_wr = psel & penable & pwrite;
	assign apb_rd = psel & ~penable & ~pwrite;
	assign status = {stow_to_ff, relay_ff, pl_ccw_lim, pl_cw_lim, az_ccw_lim, az_cw_lim,
		pl_stow, el_up, el_stow, el_down, az_stow};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_ff <= '0;
			az_cw_lim_ff <= aami_pkg::LIM_RESET;
			az_ccw_lim_ff <= aami_pkg::LIM_RESET;
			pl_cw_lim_ff <= aami_pkg::LIM_RESET;
			pl_ccw_lim_ff <= aami_pkg::LIM_RESET;
			pl_stow_en_ff <= 1'b0;
		end else if (apb_wr) begin
			if (paddr == aami_pkg::ADDR_CMD) begin
				cmd_ff <= pwdata[aami_pkg::CMD_W-1:0];
			end else if (paddr == aami_pkg::ADDR_AZ_CW_LIM) begin
				az_cw_lim_ff <= pwdata[11:0];
			end else if (paddr == aami_pkg::ADDR_AZ_CCW_LIM) begin
				az_ccw_lim_ff <= pwdata[11:0];
			end else if (paddr == aami_pkg::ADDR_PL_CW_LIM) begin
				pl_cw_lim_ff <= pwdata[11:0];
			end else if (paddr == aami_pkg::ADDR_PL_CCW_LIM) begin
				pl_ccw_lim_ff <= pwdata[11:0];
			end else if (paddr == aami_pkg::ADDR_CFG) begin
				pl_stow_en_ff <= pwdata[aami_pkg::CFG_PL_STOW_EN];
			end
		end
	end

	// Read data latched in setup so it is a flop output in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			pready <= 1'b1;
		end else if (psel && !penable) begin
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (paddr == aami_pkg::ADDR_CMD) begin
				prdata <= 32'(cmd_ff);
			end else if (paddr == aami_pkg::ADDR_AZ_CW_LIM) begin
				prdata <= 32'(az_cw_lim_ff);
			end else if (paddr == aami_pkg::ADDR_AZ_CCW_LIM) begin
				prdata <= 32'(az_ccw_lim_ff);
			end else if (paddr == aami_pkg::ADDR_PL_CW_LIM) begin
				prdata <= 32'(pl_cw_lim_ff);
			end else if (paddr == aami_pkg::ADDR_PL_CCW_LIM) begin
				prdata <= 32'(pl_ccw_lim_ff);
			end else if (paddr == aami_pkg::ADDR_CFG) begin
				prdata <= 32'(pl_stow_en_ff);
			end else if (paddr == aami_pkg::ADDR_STATUS) begin
				prdata <= apb_rd ? 32'(status) : 32'h0000_0000;
			end else if (paddr == aami_pkg::ADDR_FAULT) begin
				prdata <= 32'(jam_ff);
			end else begin
				pslverr <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	az_el_down_a: assert property (@(posedge pclk) disable iff (!presetn)
		el_down |=> !(drv_az_cw || drv_az_ccw))
		else $error("azimuth driven with elevation down");
	az_cw_a: assert property (@(posedge pclk) disable iff (!presetn)
		drv_az_cw |-> $past(!az_cw_lim)) else $error("azimuth cw past limit");
	az_ccw_a: assert property (@(posedge pclk) disable iff (!presetn)
		drv_az_ccw |-> $past(!az_ccw_lim)) else $error("azimuth ccw past limit");
	el_below_a: assert property (@(posedge pclk) disable iff (!presetn)
		drv_el_dn |-> $past(!el_down || az_stow)) else $error("elevation below down");
	el_stow_a: assert property (@(posedge pclk) disable iff (!presetn)
		drv_el_dn |-> $past(!el_stow)) else $error("elevation down past stow");
	el_up_a: assert property (@(posedge pclk) disable iff (!presetn)
		drv_el_up |-> $past(!el_up)) else $error("elevation up past limit");
	pl_lim_a: assert property (@(posedge pclk) disable iff (!presetn)
		drv_pl_ccw |-> $past(!pl_ccw_lim)) else $error("pol ccw past limit");
	pl_cw_a: assert property (@(posedge pclk) disable iff (!presetn)
		drv_pl_cw |-> $past(!pl_cw_lim)) else $error("pol cw past limit");
	relay_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		moving |=> safety_relay) else $error("relay open during motion");
	jam_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		jam_ff[0] |=> !drv_az_cw && !drv_az_ccw) else $error("jammed axis driven");
	el_plstow_a: assert property (@(posedge pclk) disable iff (!presetn)
		drv_el_dn |-> $past(!el_down || !pl_stow_en_ff || pl_stow))
		else $error("elevation below down without pol stow");
	stow_to_a: assert property (@(posedge pclk) disable iff (!presetn)
		stow_to_ff |=> !drv_el_dn)
		else $error("elevation driven after stow timeout");
	deb_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(sw_deb_ff) |-> $past(sw_s2_ff != sw_deb_ff) && $past(sw_s2_ff != sw_deb_ff, 2))
		else $error("switch accepted without settling");
	mv_c: cover property (@(posedge pclk) disable iff (!presetn) $fell(moving));
	jam_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(jam_ff[0]));
	stow_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(stow_to_ff));
	eldn_c: cover property (@(posedge pclk) disable iff (!presetn) drv_el_dn && el_down);
	plstow_c: cover property (@(posedge pclk) disable iff (!presetn) drv_el_dn && pl_stow_en_ff);
endmodule : aami_interlock

// [verification/aami_mount_model.sv]
// Mount model: limit contacts and position pots that follow the drive relays
`timescale 1ns/100ps
module aami_mount_model (
	input wire logic pclk,
	input wire logic [5:0] drv,
	input wire logic [2:0] stuck,
	input wire logic [4:0] closed,
	output logic sw_az_stow_n,
	output logic sw_el_down_n,
	output logic sw_el_stow_n,
	output logic sw_el_up_n,
	output logic sw_pl_stow_n,
	output logic [11:0] az_pos,
	output logic [11:0] el_pos,
	output logic [11:0] pl_pos
);
	logic [2:0] step_ff = 3'h0;
	initial begin
		az_pos = 12'h800;
		el_pos = 12'h800;
		pl_pos = 12'h800;
	end
	// Contacts pull high when open, so a closed contact reads low
	assign sw_az_stow_n = ~closed[0];
	assign sw_el_down_n = ~closed[1];
	assign sw_el_stow_n = ~closed[2];
	assign sw_el_up_n = ~closed[3];
	assign sw_pl_stow_n = ~closed[4];
	// Slow mechanics: one count every 8 cycles, well inside the jam window
	always @(posedge pclk) begin
		step_ff <= step_ff + 3'h1;
		if (step_ff == 3'h0) begin
			if (!stuck[0]) az_pos <= az_pos + 12'(drv[0]) - 12'(drv[1]);
			if (!stuck[1]) el_pos <= el_pos + 12'(drv[2]) - 12'(drv[3]);
			if (!stuck[2]) pl_pos <= pl_pos + 12'(drv[4]) - 12'(drv[5]);
		end
	end
endmodule : aami_mount_model

// [verification/aami_interlock_tb.sv]
// Self-checking bench for the axis motion interlock
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fails++; \
	$display("BAD %s exp %h got %h", nm, ex, got); end end
module aami_interlock_tb;
	localparam int RLY = 50;
	localparam int JAM = 40;
	localparam int STW = 100;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, relay, err;
	logic [2:0] stuck = 3'h0;
	logic [4:0] closed = 5'h00;
	logic sw_a, sw_d, sw_s, sw_u, sw_p;
	logic [11:0] azp, elp, plp;
	logic [5:0] drv;
	int fails = 0, comparisons = 0, lows;
	logic [7:0] lim_a [4] = '{8'h04, 8'h08, 8'h0C, 8'h10};
	logic [11:0] on_v [4] = '{12'h000, 12'hFFF, 12'h000, 12'hFFF};
	logic [11:0] off_v [4] = '{12'hF00, 12'h100, 12'hF00, 12'h100};
	int bit_i [4] = '{0, 1, 4, 5};
	always #12.5 pclk = ~pclk;
	aami_interlock #(.RELAY_CYC(RLY), .JAM_TO_CYC(JAM), .STOW_TO_CYC(STW), .DEB_CYC(4))
	aami_interlock_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sw_az_stow_n(sw_a), .sw_el_down_n(sw_d), .sw_el_stow_n(sw_s),
		.sw_el_up_n(sw_u), .sw_pl_stow_n(sw_p), .az_pos(azp), .el_pos(elp), .pl_pos(plp),
		.drv_az_cw(drv[0]), .drv_az_ccw(drv[1]), .drv_el_up(drv[2]), .drv_el_dn(drv[3]),
		.drv_pl_cw(drv[4]), .drv_pl_ccw(drv[5]), .safety_relay(relay));
	aami_mount_model aami_mount_model_inst (.pclk(pclk), .drv(drv), .stuck(stuck),
		.closed(closed), .sw_az_stow_n(sw_a), .sw_el_down_n(sw_d), .sw_el_stow_n(sw_s),
		.sw_el_up_n(sw_u), .sw_pl_stow_n(sw_p), .az_pos(azp), .el_pos(elp), .pl_pos(plp));
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Settle past the edge before sampling registered outputs
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : tick
	task automatic cmd(input logic [7:0] c);
		apb(1'b1, 8'h00, {24'h0, c});
		tick(4);
	endtask : cmd
	task automatic sw(input logic [4:0] c);
		@(posedge pclk);
		closed <= c;
		tick(12);
	endtask : sw
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		wrap_up();
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h04, 0); `CHK("thr_rst", 32'h0, rd)
		apb(1'b0, 8'h1C, 0); `CHK("fault_rst", 32'h0, rd)
		apb(1'b0, 8'h20, 0); `CHK("unmapped", 1'b1, err)
		for (int i = 0; i < 4; i++) apb(1'b1, lim_a[i], {20'h0, off_v[i]});
		tick(12);
		apb(1'b0, 8'h18, 0); `CHK("status", 11'h01E, rd[10:0])
		sw(5'h1F);
		apb(1'b0, 8'h18, 0); `CHK("status_cl", 11'h001, rd[10:0])
		$display("test reset_and_polarity done");
		for (int i = 0; i < 4; i++) begin
			cmd(8'(1 << bit_i[i])); `CHK("drv_free", 1'b1, drv[bit_i[i]])
			apb(1'b1, lim_a[i], {20'h0, on_v[i]});
			tick(4); `CHK("drv_lim", 1'b0, drv[bit_i[i]])
			apb(1'b1, lim_a[i], {20'h0, off_v[i]});
		end
		$display("test pot_limits done");
		apb(1'b1, 8'h00, 0);
		tick(RLY - 6); `CHK("relay_hold", 1'b1, relay)
		tick(12); `CHK("relay_open", 1'b0, relay)
		$display("test relay done");
		sw(5'h1C);
		cmd(8'h01); `CHK("az_eldown", 1'b0, drv[0])
		cmd(8'h02); `CHK("az_eldown", 1'b0, drv[1])
		cmd(8'h08); `CHK("eldn_nostow", 1'b0, drv[3])
		sw(5'h1D); `CHK("eldn_azstow", 1'b1, drv[3])
		apb(1'b1, 8'h14, 1);
		tick(4); `CHK("eldn_nopl", 1'b0, drv[3])
		sw(5'h0D); `CHK("eldn_plstow", 1'b1, drv[3])
		apb(1'b1, 8'h14, 0);
		sw(5'h0B); `CHK("eldn_elstow", 1'b0, drv[3])
		apb(1'b0, 8'h18, 0); `CHK("forced_down", 1'b1, rd[1])
		sw(5'h16);
		cmd(8'h04); `CHK("elup_lim", 1'b0, drv[2])
		cmd(8'h08); `CHK("eldn_free", 1'b1, drv[3])
		$display("test switch_interlocks done");
		sw(5'h1E);
		cmd(8'h04);
		@(posedge pclk);
		closed <= 5'h16;
		repeat (2) @(posedge pclk);
		closed <= 5'h1E;
		lows = 0;
		for (int i = 0; i < 12; i++) begin
			tick(1);
			if (drv[2] !== 1'b1) lows++;
		end
		`CHK("glitch", 0, lows)
		$display("test debounce done");
		cmd(8'h01);
		stuck <= 3'h1;
		tick(JAM + 20);
		apb(1'b0, 8'h1C, 0); `CHK("jam_flag", 3'h1, rd[2:0])
		`CHK("jam_drv", 1'b0, drv[0])
		stuck <= 3'h0;
		tick(20); `CHK("jam_held", 1'b0, drv[0])
		apb(1'b1, 8'h1C, 1);
		tick(4); `CHK("jam_clr", 1'b1, drv[0])
		apb(1'b0, 8'h1C, 0); `CHK("jam_gone", 3'h0, rd[2:0])
		$display("test jam done");
		cmd(8'h48); `CHK("stow_run", 1'b1, drv[3])
		tick(STW + 10); `CHK("stow_stop", 1'b0, drv[3])
		apb(1'b0, 8'h18, 0); `CHK("stow_to", 1'b1, rd[10])
		cmd(8'h08); `CHK("stow_rel", 1'b1, drv[3])
		$display("test stow_timeout done");
		wrap_up();
	end
endmodule : aami_interlock_tb
